/* File: logic/timer_regs.vh */
// Constants for the programmable-length timer core
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
`define CNT_W 16
`define CNT_RESET 16'h0000
`define LEN_8 2'h0
`define LEN_10 2'h1
`define LEN_12 2'h2
`define LEN_16 2'h3
`define MAX_8 16'h00ff
`define MAX_10 16'h03ff
`define MAX_12 16'h0fff
`define MAX_16 16'hffff
`define SRC_EXT_PIN 2'h0
`define SRC_AUX 2'h1
`define SRC_SUBSYS 2'h2
`define SRC_EXT2 2'h3
`define MODE_STOP 2'h0
`define MODE_UP 2'h1
`define MODE_CONT 2'h2
`define MODE_UPDN 2'h3
`define LLD_WRITE 2'h0
`define LLD_ZERO 2'h1
`define LLD_ZERO_OR_PERIOD 2'h2
`define LLD_PERIOD 2'h3
`endif

/* File: logic/clock_select.v */
// Timer clock source selection and edge detection
`timescale 1ns/1ps
`include "timer_regs.vh"
module clock_select (
  clk,
  resetn,
  clk_en,
  clock_source_select,
  ext_clock_pin,
  aux_clock,
  subsystem_clock,
  second_ext_clock,
  src_rise
);
  input wire clk;
  input wire resetn;
  input wire clk_en;
  input wire [1:0] clock_source_select;
  input wire ext_clock_pin;
  input wire aux_clock;
  input wire subsystem_clock;
  input wire second_ext_clock;
  output wire src_rise;

  reg sel_src;
  reg prev_q;

  // ****************************************
  // Source multiplexer
  // ****************************************
  always @* begin
    case (clock_source_select)
      `SRC_EXT_PIN: sel_src = ext_clock_pin;
      `SRC_AUX: sel_src = aux_clock;
      `SRC_SUBSYS: sel_src = subsystem_clock;
      `SRC_EXT2: sel_src = second_ext_clock;
      default: sel_src = 1'b0;
    endcase
  end

  // Sources are sampled levels, so a rise is seen at the first clk edge that finds the new level high
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= sel_src;
    end
  end

  assign src_rise = sel_src & ~prev_q & clk_en;
endmodule

/* File: logic/clock_divider.v */
// Two cascaded down-counter clock dividers
`timescale 1ns/1ps
`include "timer_regs.vh"
module clock_divider (
  clk,
  resetn,
  clk_en,
  clear,
  running,
  src_rise,
  prescale_divider,
  extra_divider,
  tick
);
  input wire clk;
  input wire resetn;
  input wire clk_en;
  input wire clear;
  input wire running;
  input wire src_rise;
  input wire [1:0] prescale_divider;
  input wire [2:0] extra_divider;
  output wire tick;

  reg [2:0] pre_q;
  reg [2:0] ext_q;
  reg [2:0] pre_reload;
  wire pre_out;

  // ****************************************
  // Reload values
  // ****************************************
  always @* begin
    case (prescale_divider)
      2'h0: pre_reload = 3'h0;
      2'h1: pre_reload = 3'h1;
      2'h2: pre_reload = 3'h3;
      2'h3: pre_reload = 3'h7;
      default: pre_reload = 3'h0;
    endcase
  end

  // Zero count means first edge after clear passes straight through
  assign pre_out = running & src_rise & (pre_q == 3'h0);
  assign tick = pre_out & (ext_q == 3'h0);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 3'h0;
      ext_q <= 3'h0;
    end else if (clk_en) begin
      if (clear) begin
        pre_q <= 3'h0;
        ext_q <= 3'h0;
      end else if (running && src_rise) begin
        if (pre_q == 3'h0) begin
          pre_q <= pre_reload;
          if (ext_q == 3'h0) begin
            ext_q <= extra_divider;
          end else begin
            ext_q <= ext_q - 3'h1;
          end
        end else begin
          pre_q <= pre_q - 3'h1;
        end
      end
    end
  end
endmodule

/* File: logic/timer_core.v */
// Programmable-length timer counter core
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_core (
  clk,
  resetn,
  clk_en,
  ext_clock_pin,
  aux_clock,
  subsystem_clock,
  second_ext_clock,
  clock_source_select,
  prescale_divider,
  extra_divider,
  length_select,
  run_mode_select,
  latch_load_select,
  clear_command,
  count_wr,
  count_wdata,
  compare_wr,
  channel0_compare_value,
  channel0_flag_clr,
  overflow_flag_clr,
  channel0_irq_en,
  overflow_irq_en,
  outputs_float,
  count_value,
  period_latch,
  count_down,
  clear_readback,
  channel_flag,
  overflow_flag,
  channel0_irq,
  overflow_irq,
  out_float
);
  input wire clk;
  input wire resetn;
  input wire clk_en;
  input wire ext_clock_pin;
  input wire aux_clock;
  input wire subsystem_clock;
  input wire second_ext_clock;
  input wire [1:0] clock_source_select;
  input wire [1:0] prescale_divider;
  input wire [2:0] extra_divider;
  input wire [1:0] length_select;
  input wire [1:0] run_mode_select;
  input wire [1:0] latch_load_select;
  input wire clear_command;
  input wire count_wr;
  input wire [15:0] count_wdata;
  input wire compare_wr;
  input wire [15:0] channel0_compare_value;
  input wire channel0_flag_clr;
  input wire overflow_flag_clr;
  input wire channel0_irq_en;
  input wire overflow_irq_en;
  input wire outputs_float;
  output reg [15:0] count_value;
  output reg [15:0] period_latch;
  output reg count_down;
  output wire clear_readback;
  output wire channel_flag;
  output wire overflow_flag;
  output wire channel0_irq;
  output wire overflow_irq;
  output wire out_float;

  // ****************************************
  // Helpers
  // ****************************************
  function [15:0] len_max;
    input [1:0] len;
    begin
      case (len)
        `LEN_8: len_max = `MAX_8;
        `LEN_10: len_max = `MAX_10;
        `LEN_12: len_max = `MAX_12;
        default: len_max = `MAX_16;
      endcase
    end
  endfunction

  wire src_rise;
  wire tick;
  wire running;
  wire [15:0] cmax;
  reg [15:0] cnt_d;
  reg down_d;
  reg set_cmp;
  reg set_ovf;
  reg lat_zero;
  reg lat_period;
  reg load_now;
  reg wr_pend_q;
  reg was_stopped_q;
  wire step_ok;
  wire up_entry;
  wire [1:0] flag_set;
  wire [1:0] flag_clr;
  wire [1:0] flag_now;

  assign running = run_mode_select != `MODE_STOP;
  assign cmax = len_max(length_select);
  assign clear_readback = 1'b0;
  assign out_float = outputs_float;
  assign channel0_irq = channel_flag & channel0_irq_en;
  assign overflow_irq = overflow_flag & overflow_irq_en;

  // ****************************************
  // Step gating
  // ****************************************
  // A clear, a write or an up entry swallows the tick that shares its cycle
  assign up_entry = was_stopped_q && (run_mode_select == `MODE_UP) &&
    (count_value > period_latch);
  assign step_ok = !clear_command && !count_wr && !up_entry;
  assign flag_set = {set_ovf, set_cmp} & {2{step_ok}};
  assign flag_clr = {overflow_flag_clr, channel0_flag_clr};
  assign channel_flag = flag_now[0];
  assign overflow_flag = flag_now[1];

  // ****************************************
  // Clock path
  // ****************************************
  clock_select u_sel (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .clock_source_select(clock_source_select),
    .ext_clock_pin(ext_clock_pin),
    .aux_clock(aux_clock),
    .subsystem_clock(subsystem_clock),
    .second_ext_clock(second_ext_clock),
    .src_rise(src_rise)
  );

  clock_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(clear_command),
    .running(running),
    .src_rise(src_rise),
    .prescale_divider(prescale_divider),
    .extra_divider(extra_divider),
    .tick(tick)
  );

  // ****************************************
  // Next count
  // ****************************************
  always @* begin
    cnt_d = count_value;
    down_d = count_down;
    set_cmp = 1'b0;
    set_ovf = 1'b0;
    lat_zero = 1'b0;
    lat_period = 1'b0;
    if (tick) begin
      case (run_mode_select)
        `MODE_UP: begin
          if (count_value >= period_latch) begin
            cnt_d = 16'h0000;
            lat_zero = 1'b1;
            if (count_value == period_latch) begin
              set_ovf = 1'b1;
            end
          end else begin
            cnt_d = (count_value + 16'h0001) & cmax;
            if (cnt_d == period_latch) begin
              set_cmp = 1'b1;
              lat_period = 1'b1;
            end
          end
        end
        `MODE_CONT: begin
          if (count_value >= cmax) begin
            cnt_d = 16'h0000;
            set_ovf = 1'b1;
            lat_zero = 1'b1;
          end else begin
            cnt_d = count_value + 16'h0001;
          end
        end
        `MODE_UPDN: begin
          // Latch above length maximum counts as continuous but raises no flags
          if (period_latch > cmax) begin
            cnt_d = (count_value >= cmax) ? 16'h0000 :
              count_value + 16'h0001;
            down_d = 1'b0;
          end else if (!count_down) begin
            if (count_value >= period_latch) begin
              down_d = 1'b1;
              cnt_d = (count_value == 16'h0000) ? 16'h0000 :
                count_value - 16'h0001;
            end else begin
              cnt_d = count_value + 16'h0001;
              if (cnt_d == period_latch) begin
                set_cmp = 1'b1;
                lat_period = 1'b1;
              end
            end
          end else begin
            if (count_value == 16'h0000) begin
              down_d = 1'b0;
              cnt_d = 16'h0001;
            end else begin
              cnt_d = count_value - 16'h0001;
              if (cnt_d == 16'h0000) begin
                set_ovf = 1'b1;
                lat_zero = 1'b1;
              end
            end
          end
        end
        default: cnt_d = count_value;
      endcase
    end
  end

  // ****************************************
  // Period latch load timing
  // ****************************************
  always @* begin
    case (latch_load_select)
      `LLD_WRITE: load_now = compare_wr;
      `LLD_ZERO: load_now = wr_pend_q & step_ok & lat_zero;
      `LLD_ZERO_OR_PERIOD: load_now = wr_pend_q & step_ok & (lat_zero |
        (run_mode_select == `MODE_UPDN && lat_period));
      `LLD_PERIOD: load_now = wr_pend_q & step_ok & lat_period;
      default: load_now = 1'b0;
    endcase
  end

  // ****************************************
  // State
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_value <= `CNT_RESET;
      was_stopped_q <= 1'b1;
    end else if (clk_en) begin
      was_stopped_q <= (run_mode_select == `MODE_STOP);
      if (clear_command) begin
        count_value <= `CNT_RESET;
      end else if (count_wr) begin
        // Direct loads raise no flags
        count_value <= count_wdata & cmax;
      end else if (up_entry) begin
        count_value <= `CNT_RESET;
      end else begin
        count_value <= cnt_d;
      end
    end
  end

  // ****************************************
  // Count direction
  // ****************************************
  // Latched across stop; a clear, or an up/down step with the latch above the length maximum, forces it back to up
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_down <= 1'b0;
    end else if (clk_en) begin
      if (clear_command) begin
        count_down <= 1'b0;
      end else if (step_ok) begin
        count_down <= down_d;
      end
    end
  end

  // ****************************************
  // Period latch
  // ****************************************
  // Except on write timing, a transfer rides only on a real step, so lost ticks load nothing
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_latch <= `CNT_RESET;
      wr_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (load_now) begin
        period_latch <= channel0_compare_value;
        wr_pend_q <= 1'b0;
      end else if (compare_wr) begin
        wr_pend_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sticky flags
  // ****************************************
  // Set wins over a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_flag
      reg hold_q;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          hold_q <= 1'b0;
        end else if (clk_en) begin
          if (flag_set[g]) begin
            hold_q <= 1'b1;
          end else if (flag_clr[g]) begin
            hold_q <= 1'b0;
          end
        end
      end
      assign flag_now[g] = hold_q;
    end
  endgenerate
endmodule

/* File: bench/timer_core_sva.sv */
// Assertion checker for the timer counter core
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_core_sva (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire [1:0] length_select,
  input wire [1:0] latch_load_select,
  input wire clear_command,
  input wire count_wr,
  input wire [15:0] count_wdata,
  input wire channel0_flag_clr,
  input wire overflow_flag_clr,
  input wire channel0_irq_en,
  input wire overflow_irq_en,
  input wire outputs_float,
  input wire [15:0] count_value,
  input wire [15:0] period_latch,
  input wire clear_readback,
  input wire channel_flag,
  input wire overflow_flag,
  input wire channel0_irq,
  input wire overflow_irq,
  input wire out_float
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [15:0] len_mask = (length_select == `LEN_8) ? `MAX_8 :
    (length_select == `LEN_10) ? `MAX_10 :
    (length_select == `LEN_12) ? `MAX_12 : `MAX_16;
  clear_zero_a: assert property (
    clear_command && clk_en |=> count_value == 16'h0000)
    else $error("count not zero after clear");
  write_mask_a: assert property (
    count_wr && !clear_command && clk_en
    |=> count_value == $past(len_mask & count_wdata))
    else $error("written count not masked to length");
  write_quiet_a: assert property (
    count_wr && clk_en && !channel_flag && !overflow_flag
    |=> !channel_flag && !overflow_flag)
    else $error("flag raised by a count write");
  ovf_wrap_a: assert property ($rose(overflow_flag) |->
    count_value == 16'h0000)
    else $error("overflow flag set away from zero");
  cmp_latch_a: assert property ($rose(channel_flag) &&
    latch_load_select == `LLD_WRITE && $stable(period_latch)
    |-> count_value == period_latch)
    else $error("compare flag set off the period latch");
  cflag_hold_a: assert property (
    channel_flag && !channel0_flag_clr |=> channel_flag)
    else $error("compare flag dropped without clear");
  oflag_hold_a: assert property (
    overflow_flag && !overflow_flag_clr |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  irq_gate_a: assert property (
    channel0_irq == (channel_flag && channel0_irq_en) &&
    overflow_irq == (overflow_flag && overflow_irq_en))
    else $error("request not flag and enable");
  float_pass_a: assert property (out_float == outputs_float)
    else $error("float output does not follow control");
  clr_read_a: assert property (clear_readback == 1'b0)
    else $error("clear bit reads nonzero");
endmodule
bind timer_core timer_core_sva i_timer_core_sva (
  .clk(clk), .resetn(resetn), .clk_en(clk_en),
  .length_select(length_select), .latch_load_select(latch_load_select),
  .clear_command(clear_command), .count_wr(count_wr),
  .count_wdata(count_wdata), .channel0_flag_clr(channel0_flag_clr),
  .overflow_flag_clr(overflow_flag_clr),
  .channel0_irq_en(channel0_irq_en), .overflow_irq_en(overflow_irq_en),
  .outputs_float(outputs_float), .count_value(count_value),
  .period_latch(period_latch), .clear_readback(clear_readback),
  .channel_flag(channel_flag), .overflow_flag(overflow_flag),
  .channel0_irq(channel0_irq), .overflow_irq(overflow_irq),
  .out_float(out_float)
);

/* File: bench/timer_core_bench.sv */
// Self-checking bench for the timer counter core
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_core_bench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] src = 4'h0;
  reg [1:0] csel = 2'h0, pre = 2'h0, len = 2'h3, mode = 2'h0;
  reg [2:0] ext = 3'h0;
  reg clr = 1'b0, cwr = 1'b0, pwr = 1'b0, cfc = 1'b0, ofc = 1'b0;
  reg cie = 1'b0, oie = 1'b0, flt = 1'b0, en = 1'b1;
  reg [15:0] wdata = 16'h0000, cmp = 16'h0000;
  wire [15:0] cnt, latch;
  wire dir, crb, cfl, ofl, cirq, oirq, ofloat;
  integer n_fail = 0, check_count = 0, cycles = 0;
  integer i, k, n;
  timer_core i_timer_core (
    .clk(clk), .resetn(resetn), .clk_en(en), .ext_clock_pin(src[0]),
    .aux_clock(src[1]), .subsystem_clock(src[2]),
    .second_ext_clock(src[3]), .clock_source_select(csel),
    .prescale_divider(pre), .extra_divider(ext), .length_select(len),
    .run_mode_select(mode), .latch_load_select(`LLD_WRITE),
    .clear_command(clr), .count_wr(cwr), .count_wdata(wdata),
    .compare_wr(pwr), .channel0_compare_value(cmp),
    .channel0_flag_clr(cfc), .overflow_flag_clr(ofc),
    .channel0_irq_en(cie), .overflow_irq_en(oie), .outputs_float(flt),
    .count_value(cnt), .period_latch(latch), .count_down(dir),
    .clear_readback(crb), .channel_flag(cfl), .overflow_flag(ofl),
    .channel0_irq(cirq), .overflow_irq(oirq), .out_float(ofloat)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****
  // Shared tasks
  // ****
  task cyc(input integer c);
    repeat (c) @(negedge clk);
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two cycles high and two low, so every level is sampled
  task pulse(input integer s, input integer m);
    repeat (m) begin
      src[s] = 1'b1;
      cyc(2);
      src[s] = 1'b0;
      cyc(2);
    end
  endtask
  // Stop first, then clear count, divider, direction and flags
  task restart;
    mode = `MODE_STOP;
    cyc(1);
    {clr, cfc, ofc} = 3'h7;
    cyc(1);
    {clr, cfc, ofc} = 3'h0;
    cyc(1);
  endtask
  task wr(input [15:0] v);
    cwr = 1'b1;
    wdata = v;
    cyc(1);
    cwr = 1'b0;
    cyc(1);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  // ****
  // Scenarios
  // ****
  task t_reset;
    chk(cnt, 16'h0000, "count");
    chk(latch, 16'h0000, "latch");
    chk({cfl, ofl, dir, crb}, 16'h0000, "flags");
  endtask
  task t_up;
    cmp = 16'h0002;
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
    cyc(1);
    chk(latch, 16'h0002, "latch");
    restart;
    csel = `SRC_AUX;
    mode = `MODE_UP;
    pulse(1, 1);
    chk(cnt, 16'h0001, "up count");
    chk(cfl, 1'b0, "cmp early");
    pulse(1, 1);
    chk({cfl, ofl}, 16'h0002, "cmp set");
    pulse(1, 1);
    chk(cnt, 16'h0000, "up wrap");
    chk(ofl, 1'b1, "ovf set");
    {cie, oie} = 2'h2;
    cyc(1);
    chk({cirq, oirq}, 16'h0002, "irq gate");
    {cie, oie} = 2'h1;
    cfc = 1'b1;
    cyc(1);
    cfc = 1'b0;
    chk({cfl, ofl, oirq}, 16'h0003, "cmp clear");
  endtask
  task t_src;
    restart;
    mode = `MODE_CONT;
    for (k = 0; k < 4; k = k + 1) begin
      csel = k;
      for (i = 0; i < 4; i = i + 1) begin
        pulse(i, 1);
        chk(cnt, k + ((i >= k) ? 1 : 0), "source");
      end
    end
  endtask
  task t_div;
    csel = `SRC_AUX;
    for (k = 0; k < 6; k = k + 1) begin
      mode = `MODE_STOP;
      cyc(1);
      pre = k % 4;
      ext = (k * 3) % 8;
      n = (1 << pre) * (ext + 1);
      restart;
      mode = `MODE_CONT;
      pulse(1, 2 * n + 1);
      chk(cnt, 16'h0003, "divide");
    end
    mode = `MODE_STOP;
    cyc(1);
    {pre, ext} = 5'h00;
  endtask
  task t_len;
    for (k = 0; k < 4; k = k + 1) begin
      len = k;
      restart;
      wr(16'hffff);
      chk(cnt, (k == 3) ? 16'hffff : (16'h0100 << (2 * k)) - 1, "mask");
      mode = `MODE_CONT;
      cyc(1);
      chk(ofl, 1'b0, "write quiet");
      pulse(1, 1);
      chk(cnt, 16'h0000, "length wrap");
      chk(ofl, 1'b1, "length ovf");
    end
  endtask
  task t_updn;
    restart;
    mode = `MODE_UPDN;
    for (k = 1; k < 5; k = k + 1) begin
      pulse(1, 1);
      chk(cnt, (k == 4) ? 0 : (k == 2) ? 2 : 1, "updown");
    end
    chk({dir, ofl}, 16'h0003, "down wrap");
    restart;
    chk(cnt, 16'h0000, "clear count");
    chk(dir, 1'b0, "clear dir");
  endtask
  task t_above;
    restart;
    wr(16'h0005);
    mode = `MODE_UP;
    cyc(1);
    chk(cnt, 16'h0000, "above latch");
    pulse(1, 1);
    chk(cnt, 16'h0001, "restart count");
    chk(cfl, 1'b0, "no cmp on entry");
    en = 1'b0;
    pulse(1, 1);
    chk(cnt, 16'h0001, "frozen");
    en = 1'b1;
    flt = 1'b1;
    cyc(1);
    chk(ofloat, 1'b1, "float");
    flt = 1'b0;
  endtask
  initial begin
    cyc(20);
    resetn = 1'b1;
    cyc(1);
    t_reset;
    t_up;
    t_src;
    t_div;
    t_len;
    t_updn;
    t_above;
    end_of_test;
  end
endmodule
